// [verif/bus_controller.sv]
// Bus controller model issuing mask commands and serial polls
`timescale 1ns/1ps
module bus_controller (
	// Clock
	input wire logic clk_sys,
	// Commands to the device
	output srq_enable_pkg::mask_cmd_type mask_cmd,
	output logic serial_poll
);
	initial
	begin
		mask_cmd = '0;
		serial_poll = 1'b0;
	end
	// One-cycle strobe of write, query or poll; data inverted once released
	task automatic strobe(input bit w, input bit r, input bit p, input int v);
		@(posedge clk_sys);
		mask_cmd <= {w, r, v};
		serial_poll <= p;
		@(posedge clk_sys);
		mask_cmd <= {2'b00, ~v};
		serial_poll <= 1'b0;
	endtask
	// Mask write strobe of value v, zero clears it
	task automatic wr(input int v);
		strobe(1'b1, 1'b0, 1'b0, v);
	endtask
endmodule // bus_controller

// [verif/srq_enable_bench.sv]
// Self-checking bench for the service request enabling logic
`timescale 1ns/1ps
module srq_enable_bench;
	logic clk_sys, nrst, serial_poll, srq, oper_summary, esb_summary, mav_summary, hw2_summary;
	logic ques_event_query, hw1_event_query, clear_status;
	logic [15:0] ques_cond, ques_ptr, ques_ntr, ques_enable, ques_event;
	logic [15:0] hw1_event_set, hw1_enable, hw1_event;
	logic [7:0] status_byte;
	srq_enable_pkg::mask_cmd_type mask_cmd;
	srq_enable_pkg::mask_resp_type mask_resp;
	srq_enable_pkg::err_type err;
	int errors, n_checks, cycles;
	bus_controller bus_controller_inst (.clk_sys, .mask_cmd, .serial_poll);
	srq_enable #(.GROUP_WIDTH(16)) srq_enable_inst (.clk_sys, .nrst, .mask_cmd, .mask_resp,
		.err, .oper_summary, .esb_summary, .mav_summary, .hw2_summary, .ques_cond,
		.ques_ptr, .ques_ntr, .ques_enable, .ques_event_query, .ques_event,
		.hw1_event_set, .hw1_enable, .hw1_event_query, .hw1_event, .clear_status,
		.serial_poll, .status_byte, .srq);
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			errors++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic rd(input logic [7:0] e);
		bus_controller_inst.strobe(1'b0, 1'b1, 1'b0, 0);
		#1;
		chk({mask_resp.valid, mask_resp.value}, {1'b1, e});
	endtask
	task automatic t_basic();
		rd(8'h00);
		chk(srq, 0);
		bus_controller_inst.wr(255);
		#1;
		chk(err.valid, 0);
		rd(8'hbf);
		bus_controller_inst.wr(18);
		rd(8'h12);
		bus_controller_inst.wr(64);
		rd(8'h00);
		$display("basic test finished");
	endtask
	task automatic t_range();
		int bad[3] = '{256, -1, -222};
		foreach (bad[i])
		begin
			bus_controller_inst.wr(bad[i]);
			#1;
			chk({err.valid, err.code}, 17'h1ff22);
		end
		rd(8'h00);
		$display("range test finished");
	endtask
	task automatic t_req();
		bus_controller_inst.wr(33);
		@(posedge clk_sys);
		esb_summary <= 1'b1;
		w(3);
		chk(srq, 1);
		chk(status_byte, 8'h60);
		bus_controller_inst.strobe(1'b0, 1'b0, 1'b1, 0);
		#1;
		chk({srq, status_byte}, 9'h020);
		@(posedge clk_sys);
		esb_summary <= 1'b0;
		mav_summary <= 1'b1;
		w(3);
		chk({srq, status_byte}, 9'h010);
		@(posedge clk_sys);
		esb_summary <= 1'b1;
		w(3);
		chk(srq, 1);
		bus_controller_inst.wr(0);
		w(1);
		chk(srq, 0);
		@(posedge clk_sys);
		esb_summary <= 1'b0;
		mav_summary <= 1'b0;
		bus_controller_inst.strobe(1'b0, 1'b0, 1'b1, 0);
		#1;
		chk({srq, status_byte}, 9'h000);
		$display("request test finished");
	endtask
	task automatic t_ques();
		@(posedge clk_sys);
		ques_ptr <= 16'h0001;
		ques_ntr <= 16'h0002;
		ques_enable <= 16'h0001;
		bus_controller_inst.wr(8);
		w(1);
		@(posedge clk_sys);
		ques_cond <= 16'h0003;
		w(3);
		chk(ques_event, 16'h0001);
		chk({srq, status_byte[3]}, 2'b11);
		@(posedge clk_sys);
		ques_event_query <= 1'b1;
		@(posedge clk_sys);
		ques_event_query <= 1'b0;
		w(1);
		chk({srq, ques_event}, 17'h0);
		@(posedge clk_sys);
		ques_cond <= 16'h0000;
		w(3);
		chk({srq, ques_event}, 17'h00002);
		$display("questionable test finished");
	endtask
	task automatic t_hw1();
		@(posedge clk_sys);
		hw1_enable <= 16'h0004;
		bus_controller_inst.wr(1);
		@(posedge clk_sys);
		hw1_event_set <= 16'h0004;
		@(posedge clk_sys);
		hw1_event_set <= 16'h0000;
		w(3);
		chk(hw1_event, 16'h0004);
		chk({srq, status_byte[0]}, 2'b11);
		@(posedge clk_sys);
		hw1_event_query <= 1'b1;
		hw1_event_set <= 16'h0001;
		@(posedge clk_sys);
		hw1_event_query <= 1'b0;
		hw1_event_set <= 16'h0000;
		w(1);
		chk({srq, hw1_event}, 17'h00001);
		@(posedge clk_sys);
		clear_status <= 1'b1;
		@(posedge clk_sys);
		clear_status <= 1'b0;
		oper_summary <= 1'b1;
		hw2_summary <= 1'b1;
		w(2);
		chk({srq, hw1_event}, 17'h0);
		chk(ques_event, 16'h0000);
		chk(status_byte & 8'hbf, 8'h82);
		$display("hardware group test finished");
	endtask
	task tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		{oper_summary, esb_summary, mav_summary, hw2_summary} = '0;
		{ques_cond, ques_ptr, ques_ntr, ques_enable, hw1_event_set, hw1_enable} = '0;
		{ques_event_query, hw1_event_query, clear_status} = '0;
		nrst = 1'b0;
		repeat (20) @(posedge clk_sys);
		nrst <= 1'b1;
		t_basic();
		t_range();
		t_req();
		t_ques();
		t_hw1();
		tally_and_finish();
	end
endmodule // srq_enable_bench

// [verilog/srq_enable.sv]
// Service request enable mask and status byte summary logic
`timescale 1ns/1ps
`include "srq_enable_cfg.svh"
module srq_enable #(
	parameter int GROUP_WIDTH = `GROUP_WIDTH
)(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Mask command and response
	input wire srq_enable_pkg::mask_cmd_type mask_cmd,
	output srq_enable_pkg::mask_resp_type mask_resp,
	output srq_enable_pkg::err_type err,
	// Summary inputs from other groups
	input wire logic oper_summary,
	input wire logic esb_summary,
	input wire logic mav_summary,
	input wire logic hw2_summary,
	// Questionable group
	input wire logic [GROUP_WIDTH-1:0] ques_cond,
	input wire logic [GROUP_WIDTH-1:0] ques_ptr,
	input wire logic [GROUP_WIDTH-1:0] ques_ntr,
	input wire logic [GROUP_WIDTH-1:0] ques_enable,
	input wire logic ques_event_query,
	output logic [GROUP_WIDTH-1:0] ques_event,
	// Hardware group one, event-only
	input wire logic [GROUP_WIDTH-1:0] hw1_event_set,
	input wire logic [GROUP_WIDTH-1:0] hw1_enable,
	input wire logic hw1_event_query,
	output logic [GROUP_WIDTH-1:0] hw1_event,
	// Common commands and serial poll
	input wire logic clear_status,
	input wire logic serial_poll,
	// Status and request
	output logic [7:0] status_byte,
	output logic srq
);
	logic [7:0] mask_r;
	logic ques_summary;
	logic hw1_summary;
	logic [7:0] summ;
	logic request;
	logic request_d_r;
	logic rqs_r;
	logic write_ok;

	// Legal write values are 0 to 255 as a signed integer
	function automatic logic in_range(input logic signed [31:0] v);
		in_range = (v >= 32'sd0) && (v <= `SRE_MAX_VALUE);
	endfunction

	// --------------------------------------------------------
	// Register groups
	// --------------------------------------------------------
	status_group #(.WIDTH(GROUP_WIDTH), .HAS_COND(1'b1)) u_ques (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.cond_in(ques_cond),
		.event_set_in('0),
		.ptr_filter(ques_ptr),
		.ntr_filter(ques_ntr),
		.enable(ques_enable),
		.event_query(ques_event_query),
		.clear_status(clear_status),
		.event_r(ques_event),
		.summary(ques_summary)
	);

	status_group #(.WIDTH(GROUP_WIDTH), .HAS_COND(1'b0)) u_hw1 (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.cond_in('0),
		.event_set_in(hw1_event_set),
		.ptr_filter('0),
		.ntr_filter('0),
		.enable(hw1_enable),
		.event_query(hw1_event_query),
		.clear_status(clear_status),
		.event_r(hw1_event),
		.summary(hw1_summary)
	);

	// --------------------------------------------------------
	// Mask register
	// --------------------------------------------------------
	assign write_ok = mask_cmd.wr_en && in_range(mask_cmd.wr_data);

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			mask_r <= `SRE_RESET;
		else if (write_ok)
			mask_r <= mask_cmd.wr_data[7:0] & `SRE_WRITE_MASK;
	end

	// Error pulse for a rejected write
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			err <= '0;
		else
		begin
			err.valid <= mask_cmd.wr_en && !write_ok;
			err.code <= `ERR_DATA_RANGE;
		end
	end

	// Query answer, one cycle after the strobe
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			mask_resp <= '0;
		else
		begin
			mask_resp.valid <= mask_cmd.rd_en;
			mask_resp.value <= mask_r;
		end
	end

	// --------------------------------------------------------
	// Status byte and service request
	// --------------------------------------------------------
	always_comb
	begin
		summ = 8'h00;
		summ[`STB_OPER_BIT] = oper_summary;
		summ[`STB_ESB_BIT] = esb_summary;
		summ[`STB_MAV_BIT] = mav_summary;
		summ[`STB_QUES_BIT] = ques_summary;
		summ[`STB_HW2_BIT] = hw2_summary;
		summ[`STB_HW1_BIT] = hw1_summary;
	end

	// Enabled causes only, bit 6 never counts
	assign request = |(summ & mask_r & `SRE_WRITE_MASK);

	// Previous request, for the new-reason edge
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			request_d_r <= 1'b0;
		else
			request_d_r <= request;
	end

	// New reason wins over a serial poll clear
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			rqs_r <= 1'b0;
		else if (request && !request_d_r)
			rqs_r <= 1'b1;
		else if (serial_poll)
			rqs_r <= 1'b0;
	end

	// Bit 6 carries the request-service flag
	always_comb
	begin
		status_byte = summ;
		status_byte[`STB_RQS_BIT] = rqs_r;
	end

	assign srq = request && rqs_r;

	// --------------------------------------------------------
	// Checks
	// --------------------------------------------------------

	chk_bit6_ignored: assert property (@(posedge clk_sys) disable iff (!nrst)
		mask_r[`STB_RQS_BIT] == 1'b0)
		else $error("mask bit 6 set");
	chk_range_reject: assert property (@(posedge clk_sys) disable iff (!nrst)
		(mask_cmd.wr_en && !in_range(mask_cmd.wr_data))
		|=> (err.valid && mask_r == $past(mask_r)))
		else $error("out of range write accepted");
	chk_write_store: assert property (@(posedge clk_sys) disable iff (!nrst)
		write_ok |=> (mask_r == ($past(mask_cmd.wr_data[7:0]) & 8'hbf)))
		else $error("mask write not stored");
	chk_query_value: assert property (@(posedge clk_sys) disable iff (!nrst)
		mask_cmd.rd_en |=> (mask_resp.valid && mask_resp.value == $past(mask_r)))
		else $error("mask query wrong");
	chk_zero_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
		(mask_r == 8'h00) |-> !srq)
		else $error("request with zero mask");
	chk_request_rise: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(request) |=> (rqs_r && srq == request))
		else $error("request not raised");
	chk_poll_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
		(serial_poll && !(request && !request_d_r)) |=> !status_byte[6])
		else $error("serial poll did not clear");
	chk_summary_masked: assert property (@(posedge clk_sys) disable iff (!nrst)
		srq |-> ((status_byte & mask_r & 8'hbf) != 8'h00))
		else $error("request without masked cause");
	chk_ques_summary: assert property (@(posedge clk_sys) disable iff (!nrst)
		status_byte[3] == |(ques_event & ques_enable))
		else $error("questionable summary wrong");
	chk_err_code: assert property (@(posedge clk_sys) disable iff (!nrst)
		err.valid |-> (err.code == `ERR_DATA_RANGE))
		else $error("wrong range error code");
	chk_good_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
		write_ok |=> !err.valid)
		else $error("error on a legal write");
	chk_mask_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
		!write_ok |=> (mask_r == $past(mask_r)))
		else $error("mask changed without a write");
	chk_resp_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
		!mask_cmd.rd_en |=> !mask_resp.valid)
		else $error("response without a query");
	chk_rqs_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
		(rqs_r && !serial_poll) |=> rqs_r)
		else $error("request bit lost without a poll");
	chk_srq_flagged: assert property (@(posedge clk_sys) disable iff (!nrst)
		srq |-> status_byte[`STB_RQS_BIT])
		else $error("request without request-service bit");
	chk_unused_bit: assert property (@(posedge clk_sys) disable iff (!nrst)
		status_byte[2] == 1'b0)
		else $error("unused status bit set");
	chk_hw1_summary: assert property (@(posedge clk_sys) disable iff (!nrst)
		status_byte[`STB_HW1_BIT] == |(hw1_event & hw1_enable))
		else $error("hardware group summary wrong");
	chk_rqs_set: assert property (@(posedge clk_sys) disable iff (!nrst)
		(request && !request_d_r) |=> status_byte[`STB_RQS_BIT])
		else $error("new reason did not set request bit");
endmodule // srq_enable

// [verilog/srq_enable_cfg.svh]
// Constants for the service request enabling logic
//
// Contract
// - Hold eight-bit service request enable mask
// - Mask query returns mask value 0..255
// - Mask write ignores bit 6
// - Negative or above 255 write rejected, error -222
// - All-zero mask means no service requests
// - Request when enabled summary bit is true; srq set on a new reason, dropped by serial poll
// - Event latches on filtered condition transitions
// - Summary true when event and enable set
// - Request bit set; serial poll clears it
// - Status byte bit assignments fixed
// - Event register cleared by query or clear-status
`ifndef SRQ_ENABLE_CFG_SVH
`define SRQ_ENABLE_CFG_SVH
`define SRE_RESET 8'h00
`define SRE_WRITE_MASK 8'hbf
`define SRE_MAX_VALUE 32'sd255
`define ERR_DATA_RANGE 16'hff22
`define STB_RQS_BIT 6
`define STB_OPER_BIT 7
`define STB_ESB_BIT 5
`define STB_MAV_BIT 4
`define STB_QUES_BIT 3
`define STB_HW2_BIT 1
`define STB_HW1_BIT 0
`define GROUP_WIDTH 16
`endif

// [verilog/srq_enable_pkg.sv]
// Types shared by the service request enabling logic
package srq_enable_pkg;
	typedef struct packed
	{
		logic wr_en;
		logic rd_en;
		logic signed [31:0] wr_data;
	} mask_cmd_type;

	typedef struct packed
	{
		logic valid;
		logic [7:0] value;
	} mask_resp_type;

	typedef struct packed
	{
		logic valid;
		logic [15:0] code;
	} err_type;

	typedef enum logic [1:0]
	{
		GRP_IDLE = 2'b00,
		GRP_READ = 2'b01
	} grp_state_type;
endpackage

// [verilog/status_group.sv]
// One status register group: condition, filters, event and enable
`timescale 1ns/1ps
`include "srq_enable_cfg.svh"
module status_group #(
	parameter int WIDTH = `GROUP_WIDTH,
	parameter bit HAS_COND = 1'b1
)(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Condition and configuration
	input wire logic [WIDTH-1:0] cond_in,
	input wire logic [WIDTH-1:0] event_set_in,
	input wire logic [WIDTH-1:0] ptr_filter,
	input wire logic [WIDTH-1:0] ntr_filter,
	input wire logic [WIDTH-1:0] enable,
	// Clearing
	input wire logic event_query,
	input wire logic clear_status,
	// Results
	output logic [WIDTH-1:0] event_r,
	output logic summary
);
	logic [WIDTH-1:0] cond_prev_r;
	logic [WIDTH-1:0] hit;

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			cond_prev_r <= '0;
		else
			cond_prev_r <= cond_in;
	end

	// Filtered transitions, or direct events when no condition register
	always_comb
	begin
		if (HAS_COND)
			hit = (cond_in & ~cond_prev_r & ptr_filter)
				| (~cond_in & cond_prev_r & ntr_filter);
		else
			hit = event_set_in;
	end

	// New events win over a clear in the same cycle
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			event_r <= '0;
		else if (event_query || clear_status)
			event_r <= hit;
		else
			event_r <= event_r | hit;
	end

	assign summary = |(event_r & enable);

	chk_event_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
		(event_query || clear_status) |=> (event_r == $past(hit)))
		else $error("event register not cleared");
endmodule // status_group
